/* File: core/twe_pkg.sv */
package twe_pkg;

  // Serial word framing
  localparam int WORD_BITS = 8;
  localparam int ACK_CLOCK = 9;
  localparam int PARKED_COUNT = 10;
  localparam int BIT_CNT_W = 4;

  // Device address word layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_PAGE_MSB = 3;
  localparam int DEV_PAGE_LSB = 1;
  localparam int DEV_RW_BIT = 0;

  // Array organisation
  localparam int ADDR_W = 11;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_IDX_W = 4;
  localparam int PAGE_COUNT = 128;
  localparam int WORD_ADDR_W = 8;

  // Write cycle timing
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam longint WRITE_CYCLE_TIME_MS = 5;
  localparam int WRITE_CYCLE_CYCLES =
    int'((WRITE_CYCLE_TIME_MS * CLK_FREQ_HZ) / 1000);

  // Pin synchroniser
  localparam int SYNC_PINS = 3;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP = 2;
  localparam logic [2:0] SYNC_RST = 3'h3;

  // Reset values
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [PAGE_BYTES-1:0] VALID_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_DEV_ADDR,
    ST_WORD_ADDR,
    ST_DATA,
    ST_READ,
    ST_PROGRAM
  } twe_state_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } twe_prog_t;

endpackage : twe_pkg

/* File: core/twe_link_shift.sv */
module twe_link_shift
  import twe_pkg::*;
(
  // Link clock and data
  input wire logic i_scl_clk,
  input wire logic i_sda,
  // Last bits shifted in, oldest in the MSB
  output logic [WORD_BITS-1:0] o_word
);

  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] shift_nxt;

  // Data only; framing lives on the reference clock, so no reset needed
  always_comb begin
    shift_nxt = {shift_r[WORD_BITS-2:0], i_sda};
  end

  always_ff @(posedge i_scl_clk) begin
    shift_r <= shift_nxt;
  end

  assign o_word = shift_r;

endmodule : twe_link_shift

/* File: core/twe_write_port.sv */
// What this block does
// RULE_01 - SDA change while SCL high is only ever start or stop.
// RULE_02 - Start is SDA falling with SCL high; expect address word next.
// RULE_03 - Stop is SDA rising with SCL high; ends the transfer.
// RULE_04 - Standby after reset and after stop once programming finishes.
// RULE_05 - Words are eight bits; device pulls SDA low on ninth clock.
// RULE_06 - Controller recovers bus with start, nine clocks, start, stop.
// RULE_07 - Address word's upper four bits must be the one-zero type pattern.
// RULE_08 - Next three address bits become the top word address bits.
// RULE_09 - Lowest address bit high means read, low means write.
// RULE_10 - Matching address acknowledged; mismatch gets none, back to standby.
// RULE_11 - Byte write: address, word address, one data byte, then stop.
// RULE_12 - Stop after write starts programming; bus ignored, no acknowledges.
// RULE_13 - Programming lasts at most five milliseconds from the stop.
// RULE_14 - Page write takes up to sixteen bytes, each acknowledged, then stop.
// RULE_15 - Only low four address bits increment, wrapping within the page.
// RULE_16 - More than sixteen bytes overwrite earlier bytes of the page.
// RULE_17 - Polling address acknowledged only after programming completes.
// RULE_18 - 128 pages of 16 bytes, 11-bit address from page bits and byte.
// RULE_19 - Write-protect high blocks all array writes; low allows them.
// RULE_20 - Write-protect high still acknowledges words but never programs.
// RULE_21 - Start or stop mid-word aborts and resynchronises bit counting.
module twe_write_port
  import twe_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
  // Reference clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Two-wire link
  input wire logic I_SCL,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // Write protect pin
  input wire logic I_WP,
  // Nonvolatile array programming port
  output twe_prog_t O_PROG,
  // Status
  output logic O_BUSY,
  output logic O_STANDBY
);

  localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
  localparam int CIDX_W = PAGE_IDX_W + 1;

  // Device address word holds the fixed type pattern
  function automatic logic type_match(input logic [WORD_BITS-1:0] w);
    type_match = (w[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE);
  endfunction : type_match

  // ------------------------------------------------------------------
  // Link clock domain: bit shifter clocked by SCL itself
  // ------------------------------------------------------------------
  logic [WORD_BITS-1:0] link_word;

  twe_link_shift i_twe_link_shift (
    .i_scl_clk(I_SCL),
    .i_sda(I_SDA_IN),
    .o_word(link_word)
  );

  // ------------------------------------------------------------------
  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
  // ------------------------------------------------------------------
  logic [SYNC_PINS-1:0] pins;
  logic [SYNC_PINS-1:0] s1_r;
  logic [SYNC_PINS-1:0] s2_r;
  logic [SYNC_PINS-1:0] s3_r;
  logic [SYNC_PINS-1:0] lvl_r;
  logic [SYNC_PINS-1:0] prev_r;
  logic [SYNC_PINS-1:0] s1_nxt;
  logic [SYNC_PINS-1:0] s2_nxt;
  logic [SYNC_PINS-1:0] s3_nxt;
  logic [SYNC_PINS-1:0] lvl_nxt;
  logic [SYNC_PINS-1:0] prev_nxt;

  assign pins = {I_WP, I_SDA_IN, I_SCL};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      always_comb begin
        s1_nxt[gi] = pins[gi];
        s2_nxt[gi] = s1_r[gi];
        s3_nxt[gi] = s2_r[gi];
        prev_nxt[gi] = lvl_r[gi];
        if (s2_r[gi] == s3_r[gi]) begin
          lvl_nxt[gi] = s3_r[gi];
        end else begin
          lvl_nxt[gi] = lvl_r[gi];
        end
      end

      always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
          s1_r[gi] <= SYNC_RST[gi];
          s2_r[gi] <= SYNC_RST[gi];
          s3_r[gi] <= SYNC_RST[gi];
          lvl_r[gi] <= SYNC_RST[gi];
          prev_r[gi] <= SYNC_RST[gi];
        end else begin
          s1_r[gi] <= s1_nxt[gi];
          s2_r[gi] <= s2_nxt[gi];
          s3_r[gi] <= s3_nxt[gi];
          lvl_r[gi] <= lvl_nxt[gi];
          prev_r[gi] <= prev_nxt[gi];
        end
      end
    end
  endgenerate

  // Bus events seen on the reference clock
  logic scl_high;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic wp_level;

  assign scl_high = lvl_r[PIN_SCL] & prev_r[PIN_SCL];
  assign scl_rise = lvl_r[PIN_SCL] & ~prev_r[PIN_SCL];
  assign scl_fall = ~lvl_r[PIN_SCL] & prev_r[PIN_SCL];
  // RULE_02 start detect
  assign start_evt = scl_high & prev_r[PIN_SDA] & ~lvl_r[PIN_SDA];
  // RULE_03 stop detect
  assign stop_evt = scl_high & ~prev_r[PIN_SDA] & lvl_r[PIN_SDA];
  assign wp_level = lvl_r[PIN_WP];

  // ------------------------------------------------------------------
  // Protocol, page buffer and write cycle
  // ------------------------------------------------------------------
  twe_state_t state_r;
  twe_state_t state_nxt;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] bit_cnt_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [7:0] pbuf_r [PAGE_BYTES];
  logic [7:0] pbuf_nxt [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid_r;
  logic [PAGE_BYTES-1:0] pvalid_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic [CIDX_W-1:0] cidx_r;
  logic [CIDX_W-1:0] cidx_nxt;
  twe_prog_t prog_r;
  twe_prog_t prog_nxt;
  logic busy_r;
  logic busy_nxt;
  logic standby_r;
  logic standby_nxt;
  logic sda_out_r;

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    ack_nxt = ack_r;
    addr_nxt = addr_r;
    pbuf_nxt = pbuf_r;
    pvalid_nxt = pvalid_r;
    timer_nxt = timer_r;
    cidx_nxt = cidx_r;
    prog_nxt = prog_r;
    prog_nxt.we = 1'b0;

    // RULE_17 no poll ack
    if (state_r == ST_PROGRAM) begin
      // RULE_12 bus ignored
      ack_nxt = 1'b0;
      bit_cnt_nxt = BIT_CNT_RST;
      if (cidx_r < CIDX_W'(PAGE_BYTES)) begin
        // RULE_16 last byte per slot wins
        if (pvalid_r[cidx_r[PAGE_IDX_W-1:0]]) begin
          prog_nxt.we = 1'b1;
          prog_nxt.addr = {addr_r[ADDR_W-1:PAGE_IDX_W],
                           cidx_r[PAGE_IDX_W-1:0]};
          prog_nxt.data = pbuf_r[cidx_r[PAGE_IDX_W-1:0]];
        end
        cidx_nxt = cidx_r + CIDX_W'(1);
      end
      // RULE_13 bounded write cycle
      if (timer_r == TIMER_W'(WRITE_CYCLES - 1)) begin
        // RULE_04 standby after cycle
        state_nxt = ST_STANDBY;
        pvalid_nxt = VALID_RST;
      end else begin
        timer_nxt = timer_r + TIMER_W'(1);
      end
    end else if (start_evt) begin
      // RULE_21 resync on start
      state_nxt = ST_DEV_ADDR;
      bit_cnt_nxt = BIT_CNT_RST;
      ack_nxt = 1'b0;
      pvalid_nxt = VALID_RST;
    end else if (stop_evt) begin
      bit_cnt_nxt = BIT_CNT_RST;
      ack_nxt = 1'b0;
      // RULE_11 stop ends write
      // RULE_19 protect blocks program
      // RULE_20 acked, never programmed
      if (state_r == ST_DATA && (|pvalid_r) && !wp_level) begin
        // RULE_12 stop starts program
        state_nxt = ST_PROGRAM;
        timer_nxt = '0;
        cidx_nxt = '0;
      end else begin
        // RULE_04 standby on stop
        state_nxt = ST_STANDBY;
        pvalid_nxt = VALID_RST;
      end
    end else if (scl_rise) begin
      // RULE_01 bits counted on clock
      if (state_r != ST_STANDBY && bit_cnt_r <= BIT_CNT_W'(WORD_BITS)) begin
        bit_cnt_nxt = bit_cnt_r + BIT_CNT_W'(1);
      end
    end else if (scl_fall) begin
      if (bit_cnt_r == BIT_CNT_W'(WORD_BITS)) begin
        // RULE_05 acknowledge word
        ack_nxt = 1'b1;
        case (state_r)
          ST_DEV_ADDR: begin
            // RULE_07 type check
            if (type_match(link_word)) begin
              // RULE_08 page bits
              addr_nxt[ADDR_W-1:WORD_ADDR_W] =
                link_word[DEV_PAGE_MSB:DEV_PAGE_LSB];
              // RULE_09 direction select
              if (link_word[DEV_RW_BIT]) begin
                state_nxt = ST_READ;
              end else begin
                state_nxt = ST_WORD_ADDR;
              end
            end else begin
              // RULE_10 mismatch no ack
              ack_nxt = 1'b0;
              bit_cnt_nxt = BIT_CNT_RST;
              state_nxt = ST_STANDBY;
            end
          end
          ST_WORD_ADDR: begin
            // RULE_18 eleven-bit address
            addr_nxt[WORD_ADDR_W-1:0] = link_word;
            state_nxt = ST_DATA;
          end
          ST_DATA: begin
            // RULE_14 each byte acknowledged
            pbuf_nxt[addr_r[PAGE_IDX_W-1:0]] = link_word;
            pvalid_nxt[addr_r[PAGE_IDX_W-1:0]] = 1'b1;
            // RULE_15 wrap inside page
            addr_nxt[PAGE_IDX_W-1:0] =
              addr_r[PAGE_IDX_W-1:0] + PAGE_IDX_W'(1);
          end
          default: begin
            ack_nxt = 1'b0;
          end
        endcase
      end else if (bit_cnt_r == BIT_CNT_W'(ACK_CLOCK)) begin
        // RULE_05 release after ninth
        ack_nxt = 1'b0;
        if (state_r == ST_READ) begin
          bit_cnt_nxt = BIT_CNT_W'(PARKED_COUNT);
        end else begin
          bit_cnt_nxt = BIT_CNT_RST;
        end
      end
    end
  end

  // Status outputs follow the next state so they stay registered
  always_comb begin
    busy_nxt = (state_nxt == ST_PROGRAM);
    standby_nxt = (state_nxt == ST_STANDBY);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state_r <= ST_STANDBY;
      bit_cnt_r <= BIT_CNT_RST;
      ack_r <= 1'b0;
      addr_r <= ADDR_RST;
      pvalid_r <= VALID_RST;
      timer_r <= '0;
      cidx_r <= '0;
      prog_r <= '0;
      busy_r <= 1'b0;
      standby_r <= 1'b1;
      sda_out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      ack_r <= ack_nxt;
      addr_r <= addr_nxt;
      pvalid_r <= pvalid_nxt;
      timer_r <= timer_nxt;
      cidx_r <= cidx_nxt;
      prog_r <= prog_nxt;
      busy_r <= busy_nxt;
      standby_r <= standby_nxt;
      sda_out_r <= 1'b0;
    end
  end

  // Page data storage, qualified by pvalid_r so no reset is needed
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_pbuf
      always_ff @(posedge I_REF_CLK) begin
        pbuf_r[gi] <= pbuf_nxt[gi];
      end
    end
  endgenerate

  // Open-drain data: only ever pulls low
  assign O_SDA_OUT = sda_out_r;
  assign O_SDA_OE = ack_r;
  assign O_PROG = prog_r;
  assign O_BUSY = busy_r;
  assign O_STANDBY = standby_r;

endmodule : twe_write_port

/* File: testbench/twe_write_port_properties.sv */
module twe_write_port_chk
  import twe_pkg::*;
#(
  parameter int WRITE_CYCLES = 2000
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Link and pins
  input wire logic I_SCL,
  input wire logic I_SDA_IN,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic I_WP,
  // Program port and status
  input wire twe_prog_t O_PROG,
  input wire logic O_BUSY,
  input wire logic O_STANDBY
);
  int busy_cnt_r;
  int busy_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = O_BUSY ? busy_cnt_r + 1 : 0;
  end

  always_ff @(posedge I_REF_CLK) begin
    busy_cnt_r <= I_RESET ? 0 : busy_cnt_nxt;
  end

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  a_sda_out_low: assert property (O_SDA_OUT == 1'b0)
    else $error("sda drive level not low");
  a_busy_no_ack: assert property (O_BUSY |-> !O_SDA_OE)
    else $error("ack during write cycle");
  a_standby_no_ack: assert property (O_STANDBY |-> !O_SDA_OE)
    else $error("ack in standby");
  a_ack_scl_low: assert property (
    $changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL))
    else $error("sda moved while scl high");
  a_we_in_busy: assert property (
    O_PROG.we |-> O_BUSY && busy_cnt_r <= 16)
    else $error("program pulse outside window");
  a_busy_bounded: assert property (
    O_BUSY |-> busy_cnt_r <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_busy_full: assert property (
    $fell(O_BUSY) |-> busy_cnt_r >= WRITE_CYCLES - 1)
    else $error("write cycle too short");
  a_standby_after: assert property (
    $fell(O_BUSY) |-> ##[0:2] O_STANDBY)
    else $error("no standby after write");
  a_busy_excl: assert property (O_BUSY |-> !O_STANDBY)
    else $error("standby while busy");
  a_wp_no_prog: assert property (
    I_WP [*8] |=> !$rose(O_BUSY))
    else $error("write cycle while protected");
  a_busy_on_stop: assert property (
    $rose(O_BUSY) |-> I_SCL && I_SDA_IN)
    else $error("write cycle without stop");

  c_prog: cover property (O_PROG.we);
  c_busy_end: cover property ($fell(O_BUSY));
  c_ack: cover property ($rose(O_SDA_OE));
endmodule : twe_write_port_chk

bind twe_write_port twe_write_port_chk #(.WRITE_CYCLES(WRITE_CYCLES))
  i_twe_write_port_chk (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
  .I_SCL(I_SCL), .I_SDA_IN(I_SDA_IN), .O_SDA_OUT(O_SDA_OUT),
  .O_SDA_OE(O_SDA_OE), .I_WP(I_WP), .O_PROG(O_PROG),
  .O_BUSY(O_BUSY), .O_STANDBY(O_STANDBY));

/* File: testbench/twe_ctl_model.sv */
module twe_ctl_model (
  // Open-drain bus lines
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 303;
  localparam time GAP = 60;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic pulse();
    #HALF o_scl = 1'b1;
    #HALF o_scl = 1'b0;
    #GAP;
  endtask : pulse

  task automatic do_start();
    o_sda_low = 1'b0;
    #HALF o_scl = 1'b1;
    #HALF o_sda_low = 1'b1;
    #HALF o_scl = 1'b0;
    #GAP;
  endtask : do_start

  task automatic do_stop();
    o_sda_low = 1'b1;
    #HALF o_scl = 1'b1;
    #HALF o_sda_low = 1'b0;
    #HALF;
  endtask : do_stop

  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      o_sda_low = !b[i];
      pulse();
    end
  endtask : bits

  task automatic send(input logic [7:0] b, output logic ack);
    bits(b, 8);
    o_sda_low = 1'b0;
    #HALF o_scl = 1'b1;
    #(HALF / 2) ack = (i_sda === 1'b0);
    #(HALF / 2) o_scl = 1'b0;
    #GAP;
  endtask : send

  task automatic recover();
    do_start();
    o_sda_low = 1'b0;
    repeat (9) pulse();
    do_start();
    do_stop();
  endtask : recover
endmodule : twe_ctl_model

/* File: testbench/tb_two_wire_eeprom_write_port.sv */
module tb_two_wire_eeprom_write_port;
  import twe_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic scl, ctl_low, sda, sda_out, sda_oe, busy, stby, ack;
  twe_prog_t prog;
  twe_prog_t log_q[$];
  int n_errors = 0;
  int n_tests = 0;

  always #5 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda = !((sda_oe & !sda_out) | ctl_low);

  twe_ctl_model i_twe_ctl_model (.o_scl(scl), .o_sda_low(ctl_low),
    .i_sda(sda));
  twe_write_port #(.WRITE_CYCLES(WCYC)) i_twe_write_port (
    .I_REF_CLK(clk), .I_RESET(rst), .I_SCL(scl), .I_SDA_IN(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_WP(wp), .O_PROG(prog),
    .O_BUSY(busy), .O_STANDBY(stby));

  // Program pulses are logged away from the edge that launches them
  always @(negedge clk) begin
    if (prog.we === 1'b1) log_q.push_back(prog);
  end

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk_bit

  task automatic chk_prog(input twe_prog_t got, input twe_prog_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t program %h", $time, got);
    end
  endtask : chk_prog

  task automatic xfer(input logic [7:0] b, input logic exp);
    i_twe_ctl_model.send(b, ack);
    chk_bit(ack, exp, "ack");
  endtask : xfer

  task automatic wait_idle();
    for (int k = 0; k < 3 * WCYC && busy !== 1'b0; k++) @(negedge clk);
    chk_bit(stby, 1'b1, "standby");
  endtask : wait_idle

  task automatic t_reset();
    chk_bit(stby, 1'b1, "reset standby");
    chk_bit(busy | sda_oe, 1'b0, "reset busy");
  endtask : t_reset

  task automatic t_byte();
    log_q.delete();
    i_twe_ctl_model.do_start();
    xfer(8'hA4, 1'b1);
    xfer(8'h35, 1'b1);
    xfer(8'h5C, 1'b1);
    i_twe_ctl_model.do_stop();
    chk_bit(busy, 1'b1, "busy");
    i_twe_ctl_model.do_start();
    xfer(8'hA4, 1'b0);
    i_twe_ctl_model.do_stop();
    wait_idle();
    chk_bit(log_q.size() == 1, 1'b1, "count");
    chk_prog(log_q[0], '{1'b1, 11'h235, 8'h5C});
    i_twe_ctl_model.do_start();
    xfer(8'hA4, 1'b1);
    i_twe_ctl_model.do_stop();
    chk_bit(busy, 1'b0, "idle");
  endtask : t_byte

  task automatic t_page();
    log_q.delete();
    i_twe_ctl_model.do_start();
    xfer(8'hAE, 1'b1);
    xfer(8'hFE, 1'b1);
    for (int i = 0; i < 18; i++) begin
      xfer(8'h40 + 8'(i), 1'b1);
    end
    i_twe_ctl_model.do_stop();
    wait_idle();
    chk_bit(log_q.size() == 16, 1'b1, "page count");
    for (int s = 0; s < 16; s++) begin
      chk_prog(log_q[s], '{1'b1, 11'h7F0 + 11'(s), 8'h42 + 8'(s)});
    end
  endtask : t_page

  task automatic t_refuse();
    i_twe_ctl_model.do_start();
    xfer(8'hB4, 1'b0);
    i_twe_ctl_model.do_stop();
    chk_bit(stby, 1'b1, "mismatch");
    i_twe_ctl_model.do_start();
    xfer(8'hA1, 1'b1);
    i_twe_ctl_model.do_stop();
    @(negedge clk) wp = 1'b1;
    log_q.delete();
    i_twe_ctl_model.do_start();
    xfer(8'hA0, 1'b1);
    xfer(8'h12, 1'b1);
    xfer(8'h99, 1'b1);
    i_twe_ctl_model.do_stop();
    chk_bit(busy | log_q.size() != 0, 1'b0, "protect");
    @(negedge clk) wp = 1'b0;
  endtask : t_refuse

  task automatic t_abort();
    log_q.delete();
    i_twe_ctl_model.do_start();
    i_twe_ctl_model.bits(8'hA0, 4);
    i_twe_ctl_model.do_start();
    xfer(8'hA0, 1'b1);
    xfer(8'h77, 1'b1);
    i_twe_ctl_model.bits(8'hFF, 3);
    i_twe_ctl_model.recover();
    chk_bit(stby, 1'b1, "recover");
    chk_bit(busy | log_q.size() != 0, 1'b0, "partial");
  endtask : t_abort

  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_byte();
    t_page();
    t_refuse();
    t_abort();
    test_done();
  end

  initial begin
    #1ms;
    n_errors++;
    test_done();
  end
endmodule : tb_two_wire_eeprom_write_port
